// ===== verilog/bbrtc_params.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  battery-backed power-down controller with its seconds counter.
  Assumes inclusion by bare name from the design modules bbrtc_prediv and bbrtc_top.
*/
// Contract
// - Assert regulator-off output on entering power-down
// - Wake on resume pin or counter match
// - Release regulator-off output when leaving power-down
// - Back-to-back reads need no spacing
// - Write-complete flag clears on write, sets after; here only count, match, load, trim and memory writes clear it
// - Crystal source divided by 128 internally
// - Enable bit starts clock; select picks path
// - Monitor enabled: low battery sets raw flag
// - Abort bit blocks power-down on low battery
// - Battery not evaluated while powered down
// - Low battery can raise interrupt when enabled
// - 32-bit seconds counter fed by predivider
// - Trim divisor used one second in 64
// - Larger trim slows, smaller trim speeds counter
// - Two match registers wake or interrupt
// - Counter runs when enabled; load sets it
// - Counter keeps counting through power-down
// - Power-down request bit starts power-down
// - Separate pin and match resume enables
// - Enabled events ORed onto one request line
// - Event clear register write clears flag
`ifndef BBRTC_PARAMS_SVH
`define BBRTC_PARAMS_SVH

`define BBRTC_OFS_COUNT 8'h00
`define BBRTC_OFS_MATCH0 8'h04
`define BBRTC_OFS_MATCH1 8'h08
`define BBRTC_OFS_LOAD 8'h0C
`define BBRTC_OFS_CTRL 8'h10
`define BBRTC_OFS_MASK 8'h14
`define BBRTC_OFS_RAW 8'h18
`define BBRTC_OFS_MASKED 8'h1C
`define BBRTC_OFS_CLEAR 8'h20
`define BBRTC_OFS_TRIM 8'h24
`define BBRTC_OFS_MEM_LO 12'h030
`define BBRTC_OFS_MEM_HI 12'h12C

`define BBRTC_CTL_REQ 0
`define BBRTC_CTL_CNT_EN 1
`define BBRTC_CTL_CLOCK_SOURCE_SELECT 2
`define BBRTC_CTL_PIN_WEN 3
`define BBRTC_CTL_MATCH_WEN 4
`define BBRTC_CTL_BAT_EN 5
`define BBRTC_CTL_CLK_EN 6
`define BBRTC_CTL_ABORT 7
`define BBRTC_CTL_WRC 31

`define BBRTC_EV_M0 0
`define BBRTC_EV_M1 1
`define BBRTC_EV_BATTERY_LOW_FLAG 2
`define BBRTC_EV_PIN 3

`define BBRTC_TRIM_RESET 16'h7FFF
`define BBRTC_TRIM_NOMINAL 16'h7FFF
`define BBRTC_XTAL_DIV 8'h80
`define BBRTC_TRIM_PERIOD 6'h3F
`define BBRTC_WRITE_SETTLE 3'h4
`define BBRTC_MEM_WORDS 64

`endif

// ===== verilog/bbrtc_pkg.sv
/*
  Types of the battery-backed power-down controller.
  Assumes bbrtc_params.svh on the include path.
*/
package bbrtc_pkg;

  // ****************************************
  // Power state and bus carrier
  // ****************************************
  typedef enum logic [1:0] {
    BBRTC_RUN,
    BBRTC_DOWN,
    BBRTC_WAKE
  } bbrtc_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } bbrtc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } bbrtc_wb_rsp_t;

endpackage

// ===== verilog/bbrtc_mem.sv
/*
  Retained memory of 64 words, registered read data.
  Assumes one clock shared with the controller.
*/
`timescale 1ns/1ps
module bbrtc_mem (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [5:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem_r [0:63];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
    rdata_o <= mem_r[addr_i];
  end
endmodule

// ===== verilog/bbrtc_prediv.sv
/*
  Predivider producing one tick per second from the 32.768 kHz reference,
  using the trim value as divisor once every 64 seconds.
  Assumes a one-cycle reference tick from the controller.
*/
`include "bbrtc_params.svh"
`timescale 1ns/1ps
module bbrtc_prediv (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic ref_tick_i,
  input wire logic restart_i,
  input wire logic [15:0] trim_i,
  output logic sec_tick_o
);
  logic [15:0] cnt_r;
  logic [5:0] sec_idx_r;

  // Countdown, trimmed divisor in the last second of every 64
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      cnt_r <= `BBRTC_TRIM_NOMINAL;
      sec_idx_r <= 6'h00;
      sec_tick_o <= 1'b0;
    end else begin
      sec_tick_o <= 1'b0;
      if (run_i && ref_tick_i) begin
        if (cnt_r == 16'h0000) begin
          sec_tick_o <= 1'b1;
          sec_idx_r <= sec_idx_r + 6'h01;
          if (sec_idx_r == (`BBRTC_TRIM_PERIOD - 6'h01)) begin
            cnt_r <= trim_i;
          end else begin
            cnt_r <= `BBRTC_TRIM_NOMINAL;
          end
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end
endmodule

// ===== verilog/bbrtc_top.sv
/*
  Battery-backed power-down controller: control register, seconds counter,
  match registers, battery monitor, raw and masked event status, retained
  memory, regulator-off output. Classic Wishbone slave.
  Assumes pins and clock inputs come from outside the clock domain.
*/
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`include "bbrtc_params.svh"
`timescale 1ns/1ps
module bbrtc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bbrtc_pkg::bbrtc_wb_req_t wb_req_i,
  output bbrtc_pkg::bbrtc_wb_rsp_t wb_rsp_o,
  input wire logic resume_n_i,
  input wire logic battery_low_i,
  input wire logic xtal_clk_i,
  input wire logic osc_clk_i,
  output logic regulator_off_out_n_o,
  output logic irq_o,
  output logic write_complete_flag_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic resume_n_s;
  logic bat_low_s;
  logic xtal_s;
  logic osc_s;

  always_ff @(posedge clk_i) begin
    sync1_r <= {osc_clk_i, xtal_clk_i, battery_low_i, resume_n_i};
    sync2_r <= sync1_r;
  end

  assign resume_n_s = sync2_r[0];
  assign bat_low_s = sync2_r[1];
  assign xtal_s = sync2_r[2];
  assign osc_s = sync2_r[3];

  // ****************************************
  // Registers
  // ****************************************
  logic slow_clock_enable_r;
  logic clock_source_select_r;
  logic seconds_counter_enable_r;
  logic pin_resume_enable_r;
  logic match_resume_enable_r;
  logic battery_monitor_enable_r;
  logic low_battery_abort_r;
  logic powerdown_request_r;
  logic [31:0] counter_value_r;
  logic [31:0] match_zero_r;
  logic [31:0] match_one_r;
  logic [15:0] trim_r;
  logic [3:0] event_mask_r;
  logic [3:0] raw_event_status_r;
  logic [2:0] settle_r;
  bbrtc_pkg::bbrtc_state_t state_r;

  // ****************************************
  // Bus decode
  // ****************************************
  logic access;
  logic wr;
  logic load_wr;
  logic mem_sel;
  logic mem_we;
  logic [31:0] mem_rdata;
  logic mem_pending_r;
  logic [11:0] mem_ofs;

  function automatic logic hit(input logic [11:0] adr, input logic [7:0] ofs);
    hit = (adr == {4'h0, ofs});
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = res;
  endfunction

  assign access = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign wr = access && wb_req_i.we;
  assign load_wr = wr && hit(wb_req_i.adr, `BBRTC_OFS_LOAD);
  assign mem_sel = (wb_req_i.adr >= `BBRTC_OFS_MEM_LO) && (wb_req_i.adr <= `BBRTC_OFS_MEM_HI);
  assign mem_we = wr && mem_sel && (wb_req_i.sel == 4'hF);
  assign mem_ofs = wb_req_i.adr - `BBRTC_OFS_MEM_LO;

  bbrtc_mem bbrtc_mem_inst (
    .clk_i(clk_i),
    .we_i(mem_we),
    .addr_i(mem_ofs[7:2]),
    .wdata_i(wb_req_i.dat),
    .rdata_o(mem_rdata)
  );

  // ****************************************
  // Slow reference clock
  // ****************************************
  logic xtal_d_r;
  logic osc_d_r;
  logic [6:0] xdiv_r;
  logic ref_tick_r;
  logic xtal_rise;
  logic osc_rise;

  assign xtal_rise = xtal_s && !xtal_d_r;
  assign osc_rise = osc_s && !osc_d_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_d_r <= 1'b0;
      osc_d_r <= 1'b0;
      xdiv_r <= 7'h00;
      ref_tick_r <= 1'b0;
    end else begin
      xtal_d_r <= xtal_s;
      osc_d_r <= osc_s;
      ref_tick_r <= 1'b0;
      if (slow_clock_enable_r) begin
        if (clock_source_select_r) begin
          ref_tick_r <= osc_rise;
        end else if (xtal_rise) begin
          xdiv_r <= xdiv_r + 7'h01;
          ref_tick_r <= (xdiv_r == 7'(`BBRTC_XTAL_DIV - 8'h01));
        end
      end
    end
  end

  // ****************************************
  // Seconds counter
  // ****************************************
  logic sec_tick;

  bbrtc_prediv bbrtc_prediv_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(seconds_counter_enable_r),
    .ref_tick_i(ref_tick_r),
    .restart_i(load_wr),
    .trim_i(trim_r),
    .sec_tick_o(sec_tick)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_value_r <= 32'h00000000;
    end else if (load_wr) begin
      counter_value_r <= merge(counter_value_r, wb_req_i.dat, wb_req_i.sel);
    end else if (seconds_counter_enable_r && sec_tick) begin
      counter_value_r <= counter_value_r + 32'h00000001;
    end
  end

  // ****************************************
  // Configuration writes
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_zero_r <= 32'hFFFFFFFF;
      match_one_r <= 32'hFFFFFFFF;
      trim_r <= `BBRTC_TRIM_RESET;
      event_mask_r <= 4'h0;
    end else if (wr) begin
      if (hit(wb_req_i.adr, `BBRTC_OFS_MATCH0)) begin
        match_zero_r <= merge(match_zero_r, wb_req_i.dat, wb_req_i.sel);
      end
      if (hit(wb_req_i.adr, `BBRTC_OFS_MATCH1)) begin
        match_one_r <= merge(match_one_r, wb_req_i.dat, wb_req_i.sel);
      end
      if (hit(wb_req_i.adr, `BBRTC_OFS_TRIM)) begin
        trim_r <= 16'(merge({16'h0000, trim_r}, wb_req_i.dat, wb_req_i.sel));
      end
      if (hit(wb_req_i.adr, `BBRTC_OFS_MASK) && wb_req_i.sel[0]) begin
        event_mask_r <= wb_req_i.dat[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_clock_enable_r <= 1'b0;
      clock_source_select_r <= 1'b0;
      seconds_counter_enable_r <= 1'b0;
      pin_resume_enable_r <= 1'b0;
      match_resume_enable_r <= 1'b0;
      battery_monitor_enable_r <= 1'b0;
      low_battery_abort_r <= 1'b0;
    end else if (wr && hit(wb_req_i.adr, `BBRTC_OFS_CTRL) && wb_req_i.sel[0]) begin
      slow_clock_enable_r <= wb_req_i.dat[`BBRTC_CTL_CLK_EN];
      clock_source_select_r <= wb_req_i.dat[`BBRTC_CTL_CLOCK_SOURCE_SELECT];
      seconds_counter_enable_r <= wb_req_i.dat[`BBRTC_CTL_CNT_EN];
      pin_resume_enable_r <= wb_req_i.dat[`BBRTC_CTL_PIN_WEN];
      match_resume_enable_r <= wb_req_i.dat[`BBRTC_CTL_MATCH_WEN];
      battery_monitor_enable_r <= wb_req_i.dat[`BBRTC_CTL_BAT_EN];
      low_battery_abort_r <= wb_req_i.dat[`BBRTC_CTL_ABORT];
    end
  end

  // ****************************************
  // Write-complete handshake
  // ****************************************
  logic slow_wr;

  assign slow_wr = wr && (mem_sel || hit(wb_req_i.adr, `BBRTC_OFS_COUNT)
                   || hit(wb_req_i.adr, `BBRTC_OFS_MATCH0)
                   || hit(wb_req_i.adr, `BBRTC_OFS_MATCH1)
                   || hit(wb_req_i.adr, `BBRTC_OFS_LOAD)
                   || hit(wb_req_i.adr, `BBRTC_OFS_TRIM));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_r <= 3'h0;
      write_complete_flag_o <= 1'b1;
    end else if (slow_wr) begin
      settle_r <= `BBRTC_WRITE_SETTLE;
      write_complete_flag_o <= 1'b0;
    end else if (settle_r != 3'h0) begin
      settle_r <= settle_r - 3'h1;
      write_complete_flag_o <= (settle_r == 3'h1);
    end
  end

  // ****************************************
  // Events and power state
  // ****************************************
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  logic match0;
  logic match1;
  logic low_bat_now;

  assign match0 = sec_tick && (counter_value_r == match_zero_r);
  assign match1 = sec_tick && (counter_value_r == match_one_r);
  assign low_bat_now = battery_monitor_enable_r && bat_low_s
                       && (state_r == bbrtc_pkg::BBRTC_RUN);
  assign ev_set = {!resume_n_s, low_bat_now, match1, match0};
  assign ev_clr = (wr && hit(wb_req_i.adr, `BBRTC_OFS_CLEAR) && wb_req_i.sel[0])
                  ? wb_req_i.dat[3:0] : 4'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_event_status_r <= 4'h0;
    end else begin
      raw_event_status_r <= (raw_event_status_r & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(raw_event_status_r & event_mask_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= bbrtc_pkg::BBRTC_RUN;
      powerdown_request_r <= 1'b0;
      regulator_off_out_n_o <= 1'b1;
    end else begin
      case (state_r)
        bbrtc_pkg::BBRTC_RUN: begin
          if (wr && hit(wb_req_i.adr, `BBRTC_OFS_CTRL) && wb_req_i.sel[0]
              && wb_req_i.dat[`BBRTC_CTL_REQ]) begin
            if (wb_req_i.dat[`BBRTC_CTL_ABORT] && wb_req_i.dat[`BBRTC_CTL_BAT_EN]
                && bat_low_s) begin
              powerdown_request_r <= 1'b0;
            end else begin
              powerdown_request_r <= 1'b1;
              state_r <= bbrtc_pkg::BBRTC_DOWN;
              regulator_off_out_n_o <= 1'b0;
            end
          end
        end
        bbrtc_pkg::BBRTC_DOWN: begin
          if ((pin_resume_enable_r && !resume_n_s)
              || (match_resume_enable_r && (match0 || match1))) begin
            state_r <= bbrtc_pkg::BBRTC_WAKE;
          end
        end
        bbrtc_pkg::BBRTC_WAKE: begin
          regulator_off_out_n_o <= 1'b1;
          powerdown_request_r <= 1'b0;
          state_r <= bbrtc_pkg::BBRTC_RUN;
        end
        default: begin
          state_r <= bbrtc_pkg::BBRTC_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // Read path and acknowledge
  // ****************************************
  logic [31:0] ctrl_view;
  logic [31:0] rd_data;

  always_comb begin
    ctrl_view = 32'h00000000;
    ctrl_view[`BBRTC_CTL_REQ] = powerdown_request_r;
    ctrl_view[`BBRTC_CTL_CNT_EN] = seconds_counter_enable_r;
    ctrl_view[`BBRTC_CTL_CLOCK_SOURCE_SELECT] = clock_source_select_r;
    ctrl_view[`BBRTC_CTL_PIN_WEN] = pin_resume_enable_r;
    ctrl_view[`BBRTC_CTL_MATCH_WEN] = match_resume_enable_r;
    ctrl_view[`BBRTC_CTL_BAT_EN] = battery_monitor_enable_r;
    ctrl_view[`BBRTC_CTL_CLK_EN] = slow_clock_enable_r;
    ctrl_view[`BBRTC_CTL_ABORT] = low_battery_abort_r;
    ctrl_view[`BBRTC_CTL_WRC] = write_complete_flag_o;
  end

  always_comb begin
    case (wb_req_i.adr)
      {4'h0, `BBRTC_OFS_COUNT}: rd_data = counter_value_r;
      {4'h0, `BBRTC_OFS_MATCH0}: rd_data = match_zero_r;
      {4'h0, `BBRTC_OFS_MATCH1}: rd_data = match_one_r;
      {4'h0, `BBRTC_OFS_CTRL}: rd_data = ctrl_view;
      {4'h0, `BBRTC_OFS_MASK}: rd_data = {28'h0000000, event_mask_r};
      {4'h0, `BBRTC_OFS_RAW}: rd_data = {28'h0000000, raw_event_status_r};
      {4'h0, `BBRTC_OFS_MASKED}: rd_data = {28'h0000000, raw_event_status_r & event_mask_r};
      {4'h0, `BBRTC_OFS_TRIM}: rd_data = {16'h0000, trim_r};
      default: rd_data = 32'h00000000;
    endcase
  end

  // Memory reads take one extra cycle for the registered read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_rsp_o <= '0;
      mem_pending_r <= 1'b0;
    end else begin
      wb_rsp_o.ack <= 1'b0;
      mem_pending_r <= 1'b0;
      if (access && mem_sel && !wb_req_i.we && !mem_pending_r) begin
        mem_pending_r <= 1'b1;
      end else if (mem_pending_r) begin
        wb_rsp_o.ack <= 1'b1;
        wb_rsp_o.dat <= mem_rdata;
      end else if (access) begin
        wb_rsp_o.ack <= 1'b1;
        wb_rsp_o.dat <= wb_req_i.we ? 32'h00000000 : rd_data;
      end
    end
  end

endmodule

// ===== testbench/bbrtc_top_sva.sv
/*
  Port checker for the power-down controller.
  Assumes a bind onto bbrtc_top, one clock, synchronous reset rst_i.
*/
`timescale 1ns/1ps
module bbrtc_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bbrtc_pkg::bbrtc_wb_req_t wb_req_i,
  input wire bbrtc_pkg::bbrtc_wb_rsp_t wb_rsp_o,
  input wire logic resume_n_i,
  input wire logic battery_low_i,
  input wire logic xtal_clk_i,
  input wire logic osc_clk_i,
  input wire logic regulator_off_out_n_o,
  input wire logic irq_o,
  input wire logic write_complete_flag_o
);
  logic taken;
  logic wr_ctrl;
  logic pin_wen_r;
  logic bat_en_r;
  logic [3:0] mask_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign taken = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign wr_ctrl = taken && wb_req_i.we && wb_req_i.adr == 12'h010;
  // ********
  // Tracked control and mask bits
  // ********
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_wen_r <= 1'h0;
      bat_en_r <= 1'h0;
    end else if (wr_ctrl) begin
      pin_wen_r <= wb_req_i.dat[3];
      bat_en_r <= wb_req_i.dat[5];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= 4'h0;
    end else if (taken && wb_req_i.we && wb_req_i.adr == 12'h014) begin
      mask_r <= wb_req_i.dat[3:0];
    end
  end
  // ********
  // Assertions
  // ********
  ack_single_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  ack_held_a: assert property (wb_rsp_o.ack |-> wb_req_i.cyc && wb_req_i.stb)
    else $error("ack without request");
  read_answer_a: assert property (taken && !wb_req_i.we |-> ##[1:2] wb_rsp_o.ack)
    else $error("read not answered");
  unmapped_zero_a: assert property (wb_rsp_o.ack && !wb_req_i.we
    && wb_req_i.adr inside {[12'h028:12'h02F]} |-> wb_rsp_o.dat == 32'h0)
    else $error("unmapped read not zero");
  wrc_clear_a: assert property (taken && wb_req_i.we
    && (wb_req_i.adr <= 12'h00C || wb_req_i.adr == 12'h024
    || wb_req_i.adr inside {[12'h030:12'h12C]}) |=> !write_complete_flag_o)
    else $error("write complete flag not cleared");
  wrc_return_a: assert property ($fell(write_complete_flag_o)
    |-> ##[1:8] write_complete_flag_o) else $error("write complete flag not restored");
  sleep_enter_a: assert property (wr_ctrl && wb_req_i.dat[0] && wb_req_i.dat[3]
    && !wb_req_i.dat[7] && resume_n_i && regulator_off_out_n_o
    |-> ##[1:4] !regulator_off_out_n_o) else $error("power-down not entered");
  abort_hold_a: assert property ((battery_low_i && regulator_off_out_n_o)[*6]
    ##0 (wr_ctrl && wb_req_i.dat[0] && wb_req_i.dat[5] && wb_req_i.dat[7])
    |=> regulator_off_out_n_o[*4]) else $error("power-down not refused");
  wake_pin_a: assert property (!regulator_off_out_n_o && pin_wen_r && !resume_n_i
    |-> ##[1:6] regulator_off_out_n_o) else $error("no wake from pin");
  irq_mask_a: assert property ((mask_r == 4'h0)[*3] |-> !irq_o)
    else $error("interrupt with all events masked");
  battery_low_flag_irq_a: assert property ((regulator_off_out_n_o && bat_en_r && mask_r[2]
    && battery_low_i)[*8] |-> irq_o) else $error("low battery not signalled");
  sleep_c: cover property ($fell(regulator_off_out_n_o));
  wake_c: cover property ($rose(regulator_off_out_n_o));
  irq_c: cover property ($rose(irq_o));
endmodule

// ===== testbench/bbrtc_far_side.sv
/*
  Far side: resume pin with pull-up, battery comparator, free-running
  clock sources, regulator following the off output.
  Assumes the bench commands pin and battery level.
*/
`timescale 1ns/1ps
module bbrtc_far_side (
  input wire logic wake_i,
  input wire logic bat_low_i,
  input wire logic regulator_off_n_i,
  output logic resume_n_o,
  output logic battery_low_o,
  output logic xtal_clk_o,
  output logic osc_clk_o,
  output logic supply_on_o
);
  // Pulled high unless pressed
  assign resume_n_o = !wake_i;
  assign battery_low_o = bat_low_i;
  assign supply_on_o = regulator_off_n_i;
  initial begin
    xtal_clk_o = 1'h0;
    forever #119.209 xtal_clk_o = !xtal_clk_o;
  end
  initial begin
    osc_clk_o = 1'h0;
    forever #15258.789 osc_clk_o = !osc_clk_o;
  end
endmodule

// ===== testbench/bbrtc_top_test.sv
/*
  Bench for the power-down controller: Wishbone tasks and sequences.
  Assumes the far-side model and the bound checker.
*/
`timescale 1ns/1ps
module bbrtc_top_test;
  localparam int XTAL_SETTLE = 100;
  logic clk_i, rst_i, resume_n, bat_pin, xtal_clk, osc_clk, reg_n, irq, write_complete_flag, wake, bat_low;
  bbrtc_pkg::bbrtc_wb_req_t wb_req;
  bbrtc_pkg::bbrtc_wb_rsp_t wb_rsp;
  logic [31:0] rd;
  logic [11:0] adr_tab [6] = '{12'h00C, 12'h004, 12'h008, 12'h024, 12'h030, 12'h12C};
  logic [31:0] val_tab [6] = '{32'h1234_5678, 32'hA5A5_0001, 32'h0000_FFFF, 32'h0000_8001,
    32'hCAFE_0123, 32'h0BAD_F00D};
  int err_count;
  int num_checks;
  bbrtc_top bbrtc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .resume_n_i(resume_n), .battery_low_i(bat_pin), .xtal_clk_i(xtal_clk),
    .osc_clk_i(osc_clk), .regulator_off_out_n_o(reg_n), .irq_o(irq),
    .write_complete_flag_o(write_complete_flag));
  bbrtc_far_side bbrtc_far_side_inst (.wake_i(wake), .bat_low_i(bat_low),
    .regulator_off_n_i(reg_n), .resume_n_o(resume_n), .battery_low_o(bat_pin),
    .xtal_clk_o(xtal_clk), .osc_clk_o(osc_clk), .supply_on_o());
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = !clk_i;
  end
  // ********
  // Tasks
  // ********
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= '{1'h1, 1'h1, w, 4'hF, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp.ack !== 1'h1 && n < 50);
    rd = wb_rsp.dat;
    wb_req <= '0;
    if (wb_rsp.ack !== 1'h1) begin
      err_count++;
      give_verdict();
    end
  endtask
  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    check(name, rd, e);
  endtask
  task automatic wait_on(input bit use_reg, input logic v);
    int n;
    n = 0;
    while ((use_reg ? reg_n : write_complete_flag) !== v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      give_verdict();
    end
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    err_count = 0;
    num_checks = 0;
    rst_i = 1'h1;
    wb_req = '0;
    wake = 1'h0;
    bat_low = 1'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    check("reg_off", {31'h0, reg_n}, 32'h1);
    check("irq", {31'h0, irq}, 32'h0);
    rd_chk("ctrl", 12'h010, 32'h8000_0000);
    rd_chk("match0", 12'h004, 32'hFFFF_FFFF);
    rd_chk("match1", 12'h008, 32'hFFFF_FFFF);
    rd_chk("trim", 12'h024, 32'h0000_7FFF);
    rd_chk("raw", 12'h018, 32'h0);
    bus(1'h1, 12'h010, 32'h0000_0040);
    repeat (XTAL_SETTLE) @(posedge clk_i);
    rd_chk("ctrl_xtal", 12'h010, 32'h8000_0040);
    bus(1'h1, 12'h010, 32'h0000_0044);
    rd_chk("ctrl_osc", 12'h010, 32'h8000_0044);
    for (int i = 0; i < 6; i++) begin
      bus(1'h1, adr_tab[i], val_tab[i]);
      check("wrc_low", {31'h0, write_complete_flag}, 32'h0);
      wait_on(1'b0, 1'h1);
      rd_chk("slow", (i == 0) ? 12'h000 : adr_tab[i], val_tab[i]);
    end
    bus(1'h1, 12'h028, 32'hFFFF_FFFF);
    rd_chk("unmapped", 12'h028, 32'h0);
    bus(1'h1, 12'h014, 32'h0000_0004);
    bus(1'h1, 12'h010, 32'h0000_0064);
    bat_low <= 1'h1;
    repeat (10) @(posedge clk_i);
    rd_chk("raw_low", 12'h018, 32'h0000_0004);
    rd_chk("masked_low", 12'h01C, 32'h0000_0004);
    check("irq_low", {31'h0, irq}, 32'h1);
    bat_low <= 1'h0;
    repeat (10) @(posedge clk_i);
    rd_chk("raw_kept", 12'h018, 32'h0000_0004);
    bus(1'h1, 12'h020, 32'h0000_0004);
    repeat (3) @(posedge clk_i);
    rd_chk("raw_clr", 12'h018, 32'h0);
    check("irq_clr", {31'h0, irq}, 32'h0);
    bat_low <= 1'h1;
    repeat (10) @(posedge clk_i);
    bus(1'h1, 12'h010, 32'h0000_00ED);
    repeat (8) @(posedge clk_i);
    check("abort", {31'h0, reg_n}, 32'h1);
    bus(1'h0, 12'h010, 32'h0);
    check("req_bit", {31'h0, rd[0]}, 32'h0);
    bat_low <= 1'h0;
    repeat (10) @(posedge clk_i);
    bus(1'h1, 12'h020, 32'h0000_000F);
    bus(1'h1, 12'h010, 32'h0000_006D);
    wait_on(1'b1, 1'h0);
    check("down", {31'h0, reg_n}, 32'h0);
    bat_low <= 1'h1;
    repeat (20) @(posedge clk_i);
    bat_low <= 1'h0;
    repeat (5) @(posedge clk_i);
    check("still_down", {31'h0, reg_n}, 32'h0);
    wake <= 1'h1;
    wait_on(1'b1, 1'h1);
    check("woken", {31'h0, reg_n}, 32'h1);
    wake <= 1'h0;
    repeat (5) @(posedge clk_i);
    rd_chk("raw_wake", 12'h018, 32'h0000_0008);
    rd_chk("ctrl_wake", 12'h010, 32'h8000_006C);
    bus(1'h1, 12'h010, 32'h0000_005A);
    rd_chk("ctrl_wen", 12'h010, 32'h8000_005A);
    give_verdict();
  end
endmodule

bind bbrtc_top bbrtc_top_sva bbrtc_top_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .resume_n_i(resume_n_i),
  .battery_low_i(battery_low_i), .xtal_clk_i(xtal_clk_i), .osc_clk_i(osc_clk_i),
  .regulator_off_out_n_o(regulator_off_out_n_o), .irq_o(irq_o),
  .write_complete_flag_o(write_complete_flag_o));
